// ==== verilog/timer_pair_pkg.sv ====
// Constants, field layouts and types for the dual timer and edge block
// Overview of operation
// - Transmit combines short and long outputs via logic field
// - Demodulation uses logic field as edge polarity select
// - Submode picks alternating or normal; normal ends alternating
// - Submode 10 forces long output low, 11 high
// - Demodulation uses submode as glitch filter width
// - Short timer start sets output to its initial level
// - Disabled short timer holds inverse of initial level
// - Rising edge sets flag; writing one clears it
// - Long start sets initial level, only normal/alternating
// - Disabled long timer holds inverse of initial level, except in submodes 10 and 11
// - Falling edge sets flag; writing one clears it
// - Filtered edge detector watches one of two pins
package timer_pair_pkg;

  //////////////////////////////////////////////////////////////////////////
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_MODE_CTL       = 6'h01;
  localparam logic [5:0] IDX_LONG_CTL       = 6'h02;
  localparam logic [5:0] IDX_AUX_CTL        = 6'h03;
  localparam logic [5:0] IDX_SHORT_RELOAD   = 6'h04;
  localparam logic [5:0] IDX_LONG_RELOAD_LO = 6'h05;
  localparam logic [5:0] IDX_LONG_RELOAD_HI = 6'h06;
  localparam logic [5:0] IDX_STATUS         = 6'h07;

  //////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int MODE_BIT       = 7;  // 0 transmit, 1 demodulation
  localparam int PIN_SEL_BIT    = 6;  // 0 pin a, 1 pin b
  localparam int LOGIC_HI       = 5;
  localparam int LOGIC_LO       = 4;
  localparam int SUB_HI         = 3;
  localparam int SUB_LO         = 2;
  localparam int INIT_SHORT_BIT = 1;  // Rising flag in demodulation
  localparam int INIT_LONG_BIT  = 0;  // Falling flag in demodulation
  localparam int ENABLE_BIT     = 7;  // Long and aux control

  //////////////////////////////////////////////////////////////////////////
  // Reset values and fixed read values
  localparam logic [7:0]  MODE_CTL_RESET     = 8'h00;
  localparam logic [7:0]  LONG_CTL_RESET     = 8'h00;
  localparam logic [7:0]  SHORT_RELOAD_RESET = 8'h0F;
  localparam logic [15:0] LONG_RELOAD_RESET  = 16'h00FF;
  localparam logic [4:0]  AUX_RESERVED_READ  = 5'h1F;
  localparam logic [31:0] READ_ZERO          = 32'h0000_0000;

  //////////////////////////////////////////////////////////////////////////
  // Submode encodings in transmit mode
  localparam logic [1:0] SUB_NORMAL = 2'h0;
  localparam logic [1:0] SUB_ALT    = 2'h1;
  localparam logic [1:0] SUB_FORCE0 = 2'h2;
  localparam logic [1:0] SUB_FORCE1 = 2'h3;

  // Logic function encodings in transmit mode
  localparam logic [1:0] LF_AND  = 2'h0;
  localparam logic [1:0] LF_OR   = 2'h1;
  localparam logic [1:0] LF_NOR  = 2'h2;
  localparam logic [1:0] LF_NAND = 2'h3;

  // Edge select encodings in demodulation mode
  localparam logic [1:0] EDGE_FALL  = 2'h0;
  localparam logic [1:0] EDGE_RISE  = 2'h1;
  localparam logic [1:0] EDGE_BOTH  = 2'h2;
  localparam logic [1:0] EDGE_BOTH2 = 2'h3;

  // Glitch filter lengths in clock cycles, per submode code
  localparam logic [3:0] GLITCH_LEN0 = 4'h1;
  localparam logic [3:0] GLITCH_LEN1 = 4'h2;
  localparam logic [3:0] GLITCH_LEN2 = 4'h4;
  localparam logic [3:0] GLITCH_LEN3 = 4'h8;

  // Which timer owns the turn in alternating submode
  typedef enum logic {PH_SHORT, PH_LONG} phase_type;

  // Filter length for a given glitch code
  function automatic logic [3:0] glitch_len(input logic [1:0] code);
    unique case (code)
      2'h0: glitch_len = GLITCH_LEN0;
      2'h1: glitch_len = GLITCH_LEN1;
      2'h2: glitch_len = GLITCH_LEN2;
      2'h3: glitch_len = GLITCH_LEN3;
    endcase
  endfunction

endpackage

// ==== verilog/edge_filter.sv ====
// Glitch filter and edge detector for the demodulation input
`timescale 1ns/1ps
module edge_filter (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       pin_a,
  input  wire logic       pin_b,
  input  wire logic       pin_sel,
  input  wire logic [3:0] filt_len,
  output logic            rise_pulse,
  output logic            fall_pulse
);

  typedef struct packed {
    logic       level;
    logic [3:0] cnt;
    logic       rise;
    logic       fall;
  } filt_state_type;

  filt_state_type s_r;
  filt_state_type s_nxt;
  logic           sample;
  logic [3:0]     cnt_inc;

  //////////////////////////////////////////////////////////////////////////
  // A change is accepted only after it holds for filt_len cycles
  always_comb begin
    s_nxt = s_r;
    s_nxt.rise = 1'b0;
    s_nxt.fall = 1'b0;
    sample = pin_sel ? pin_b : pin_a;
    cnt_inc = s_r.cnt + 4'h1;
    if (sample == s_r.level) begin
      s_nxt.cnt = 4'h0;  // Short pulse dies here
    end else if (cnt_inc >= filt_len) begin
      s_nxt.level = sample;
      s_nxt.cnt = 4'h0;
      s_nxt.rise = sample;
      s_nxt.fall = ~sample;
    end else begin
      s_nxt.cnt = cnt_inc;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rise_pulse = s_r.rise;
  assign fall_pulse = s_r.fall;

endmodule

// ==== verilog/timer_pair.sv ====
// Dual timer output logic and demodulation control with Wishbone slave
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ps
module timer_pair (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  input  wire logic        WE_I,
  input  wire logic [7:0]  ADR_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic [31:0] DAT_I,
  output logic [31:0]      DAT_O,
  output logic             ACK_O,
  input  wire logic        EDGE_INPUT_PIN_A,
  input  wire logic        EDGE_INPUT_PIN_B,
  output logic             SHORT_TIMER_OUTPUT,
  output logic             LONG_TIMER_OUTPUT,
  output logic             TIMER_OUT
);
  import timer_pair_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Whole state of the block
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
    logic [7:2]  mode_ctl;
    logic        init_short;
    logic        init_long;
    logic        rise_flag;
    logic        fall_flag;
    logic [7:0]  long_ctl;
    logic        short_en;
    logic [7:0]  short_reload;
    logic [15:0] long_reload;
    logic [7:0]  short_cnt;
    logic [15:0] long_cnt;
    logic        short_out;
    logic        long_out;
    logic        comb_out;
    logic        short_en_q;
    logic        long_en_q;
    phase_type   phase;
  } state_type;

  state_type  s_r;
  state_type  s_nxt;
  logic       rise_p;
  logic       fall_p;
  logic       transmit;
  logic [1:0] sub;
  logic [1:0] lfun;
  logic       hit;
  logic       wr;
  logic [5:0] idx;
  logic       en_s;
  logic       en_l;
  logic       run_s;
  logic       run_l;
  logic       rise_ok;
  logic       fall_ok;
  logic [7:0] mode_rd;

  //////////////////////////////////////////////////////////////////////////
  // Input edge detector, filter width from the submode field
  edge_filter u_edge (
    .clk        (CLK),
    .rst        (RST),
    .pin_a      (EDGE_INPUT_PIN_A),
    .pin_b      (EDGE_INPUT_PIN_B),
    .pin_sel    (s_r.mode_ctl[PIN_SEL_BIT]),
    .filt_len   (glitch_len(sub)),
    .rise_pulse (rise_p),
    .fall_pulse (fall_p)
  );

  //////////////////////////////////////////////////////////////////////////
  // Decoded control fields
  assign transmit = ~s_r.mode_ctl[MODE_BIT];
  assign sub      = s_r.mode_ctl[SUB_HI:SUB_LO];
  assign lfun     = s_r.mode_ctl[LOGIC_HI:LOGIC_LO];
  assign en_s     = s_r.short_en;
  assign en_l     = s_r.long_ctl[ENABLE_BIT];
  assign idx      = ADR_I[7:2];

  // Each slave cycle is acked once; ack drops the cycle after
  assign hit = CYC_I & STB_I & ~s_r.ack;
  assign wr  = hit & WE_I & SEL_I[0];

  // In demodulation the low two bits show the edge flags
  assign mode_rd = transmit
                 ? {s_r.mode_ctl, s_r.init_short, s_r.init_long}
                 : {s_r.mode_ctl, s_r.rise_flag, s_r.fall_flag};

  // Edge polarity chosen by the shared logic/edge field
  assign rise_ok = (lfun == EDGE_RISE) || (lfun == EDGE_BOTH)
                || (lfun == EDGE_BOTH2);
  assign fall_ok = (lfun == EDGE_FALL) || (lfun == EDGE_BOTH)
                || (lfun == EDGE_BOTH2);

  // Timers run only when enabled and, when alternating, on their turn
  assign run_s = transmit & en_s & s_r.short_en_q
               & ((sub != SUB_ALT) || (s_r.phase == PH_SHORT));
  assign run_l = transmit & en_l & s_r.long_en_q
               & ((sub == SUB_NORMAL)
                  || ((sub == SUB_ALT) && (s_r.phase == PH_LONG)));

  //////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.ack = hit;
    s_nxt.short_en_q = en_s;
    s_nxt.long_en_q = en_l;

    // Read data is captured with the ack; unmapped reads return zero
    if (hit) begin
      unique case (idx)
        IDX_MODE_CTL:       s_nxt.dat = {24'h0, mode_rd};
        IDX_LONG_CTL:       s_nxt.dat = {24'h0, s_r.long_ctl};
        IDX_AUX_CTL:
          s_nxt.dat = {24'h0, s_r.short_en, 2'h0, AUX_RESERVED_READ};
        IDX_SHORT_RELOAD:   s_nxt.dat = {24'h0, s_r.short_reload};
        IDX_LONG_RELOAD_LO: s_nxt.dat = {24'h0, s_r.long_reload[7:0]};
        IDX_LONG_RELOAD_HI: s_nxt.dat = {24'h0, s_r.long_reload[15:8]};
        IDX_STATUS:
          s_nxt.dat = {28'h0, s_r.comb_out, s_r.long_out,
                       s_r.short_out, s_r.phase == PH_LONG};
        default:            s_nxt.dat = READ_ZERO;
      endcase
    end

    // Register writes; low byte lane carries all fields
    if (wr) begin
      unique case (idx)
        IDX_MODE_CTL: begin
          s_nxt.mode_ctl = DAT_I[7:2];
          if (transmit) begin
            s_nxt.init_short = DAT_I[INIT_SHORT_BIT];
            s_nxt.init_long = DAT_I[INIT_LONG_BIT];
          end else begin
            if (DAT_I[INIT_SHORT_BIT]) begin
              s_nxt.rise_flag = 1'b0;
            end
            if (DAT_I[INIT_LONG_BIT]) begin
              s_nxt.fall_flag = 1'b0;
            end
          end
        end
        IDX_LONG_CTL:       s_nxt.long_ctl = DAT_I[7:0];
        IDX_AUX_CTL:        s_nxt.short_en = DAT_I[ENABLE_BIT];
        IDX_SHORT_RELOAD:   s_nxt.short_reload = DAT_I[7:0];
        IDX_LONG_RELOAD_LO: s_nxt.long_reload[7:0] = DAT_I[7:0];
        IDX_LONG_RELOAD_HI: s_nxt.long_reload[15:8] = DAT_I[7:0];
        default: ;
      endcase
    end

    // Edge flags set after the clear so a same-cycle edge survives
    if (!transmit && rise_p && rise_ok) begin
      s_nxt.rise_flag = 1'b1;
    end
    if (!transmit && fall_p && fall_ok) begin
      s_nxt.fall_flag = 1'b1;
    end

    // Normal submode ends any alternating run
    if (sub != SUB_ALT) begin
      s_nxt.phase = PH_SHORT;
    end

    // Short timer
    if (!en_s) begin
      s_nxt.short_out = ~s_r.init_short;
      s_nxt.short_cnt = s_r.short_reload;
    end else if (transmit && !s_r.short_en_q) begin
      s_nxt.short_out = s_r.init_short;
      s_nxt.short_cnt = s_r.short_reload;
    end else if (run_s) begin
      if (s_r.short_cnt == 8'h00) begin
        s_nxt.short_out = ~s_r.short_out;
        s_nxt.short_cnt = s_r.short_reload;
        if (sub == SUB_ALT) begin
          s_nxt.phase = PH_LONG;
        end
      end else begin
        s_nxt.short_cnt = s_r.short_cnt - 8'h01;
      end
    end

    // Long timer; forcing wins over everything while in transmit
    if (transmit && (sub == SUB_FORCE0)) begin
      s_nxt.long_out = 1'b0;
    end else if (transmit && (sub == SUB_FORCE1)) begin
      s_nxt.long_out = 1'b1;
    end else if (!en_l) begin
      s_nxt.long_out = ~s_r.init_long;
      s_nxt.long_cnt = s_r.long_reload;
    end else if (transmit && !s_r.long_en_q) begin
      s_nxt.long_out = s_r.init_long;
      s_nxt.long_cnt = s_r.long_reload;
    end else if (run_l) begin
      if (s_r.long_cnt == 16'h0000) begin
        s_nxt.long_out = ~s_r.long_out;
        s_nxt.long_cnt = s_r.long_reload;
        if (sub == SUB_ALT) begin
          s_nxt.phase = PH_SHORT;
        end
      end else begin
        s_nxt.long_cnt = s_r.long_cnt - 16'h0001;
      end
    end

    // Combined output from the registered timer outputs
    unique case (lfun)
      LF_AND:  s_nxt.comb_out = s_r.short_out & s_r.long_out;
      LF_OR:   s_nxt.comb_out = s_r.short_out | s_r.long_out;
      LF_NOR:  s_nxt.comb_out = ~(s_r.short_out | s_r.long_out);
      LF_NAND: s_nxt.comb_out = ~(s_r.short_out & s_r.long_out);
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // State register with constant reset values
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s_r <= '0;
      s_r.mode_ctl <= MODE_CTL_RESET[7:2];
      s_r.init_short <= MODE_CTL_RESET[INIT_SHORT_BIT];
      s_r.init_long <= MODE_CTL_RESET[INIT_LONG_BIT];
      s_r.long_ctl <= LONG_CTL_RESET;
      s_r.short_reload <= SHORT_RELOAD_RESET;
      s_r.long_reload <= LONG_RELOAD_RESET;
      s_r.short_cnt <= SHORT_RELOAD_RESET;
      s_r.long_cnt <= LONG_RELOAD_RESET;
      s_r.short_out <= 1'b1;  // Inverse of reset initial level
      s_r.long_out <= 1'b1;
      s_r.phase <= PH_SHORT;
    end else begin
      s_r <= s_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs straight from flip-flops
  assign DAT_O              = s_r.dat;
  assign ACK_O              = s_r.ack;
  assign SHORT_TIMER_OUTPUT = s_r.short_out;
  assign LONG_TIMER_OUTPUT  = s_r.long_out;
  assign TIMER_OUT          = s_r.comb_out;

endmodule

// ==== verif/timer_pair_sva.sv ====
// Port assertions for the timer pair block
`timescale 1ns/1ps
module timer_pair_sva
  import timer_pair_pkg::*;
(
  input wire logic        CLK,
  input wire logic        RST,
  input wire logic        CYC_I,
  input wire logic        STB_I,
  input wire logic        WE_I,
  input wire logic [7:0]  ADR_I,
  input wire logic [3:0]  SEL_I,
  input wire logic [31:0] DAT_I,
  input wire logic [31:0] DAT_O,
  input wire logic        ACK_O,
  input wire logic        SHORT_TIMER_OUTPUT,
  input wire logic        LONG_TIMER_OUTPUT,
  input wire logic        TIMER_OUT
);
  logic [7:0] mode_r;
  logic       sen_r;
  logic       len_r;
  logic       rd_aux_r;
  logic       tx;
  logic       ins;
  logic       inl;
  logic       wr;
  logic [1:0] lf;
  logic [1:0] sub;
  assign tx  = !mode_r[MODE_BIT];
  assign ins = mode_r[INIT_SHORT_BIT];
  assign inl = mode_r[INIT_LONG_BIT];
  assign lf  = mode_r[LOGIC_HI:LOGIC_LO];
  assign sub = mode_r[SUB_HI:SUB_LO];
  assign wr  = CYC_I && STB_I && WE_I && !ACK_O && SEL_I[0];

  function automatic logic mix(input logic [1:0] f, input logic s, l);
    case (f)
      LF_AND:  mix = s & l;
      LF_OR:   mix = s | l;
      LF_NOR:  mix = ~(s | l);
      default: mix = ~(s & l);
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Shadow of control bits; flag writes in demodulation keep init bits
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      mode_r   <= MODE_CTL_RESET;
      sen_r    <= 1'b0;
      len_r    <= 1'b0;
      rd_aux_r <= 1'b0;
    end else begin
      rd_aux_r <= CYC_I && STB_I && !WE_I && !ACK_O
                  && ADR_I[7:2] == IDX_AUX_CTL;
      if (wr && ADR_I[7:2] == IDX_MODE_CTL)
        mode_r <= tx ? DAT_I[7:0] : {DAT_I[7:2], mode_r[1:0]};
      if (wr && ADR_I[7:2] == IDX_AUX_CTL)
        sen_r <= DAT_I[ENABLE_BIT];
      if (wr && ADR_I[7:2] == IDX_LONG_CTL)
        len_r <= DAT_I[ENABLE_BIT];
    end
  end

  default clocking @(posedge CLK); endclocking
  default disable iff (RST);

  // Bus answers exactly one cycle after the take, for one cycle
  AST_ACK_ONE: assert property (ACK_O |=> !ACK_O)
    else $error("ack held too long");
  AST_ACK_ANS: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
    else $error("request not acked");
  AST_AUX_READ: assert property (ACK_O && rd_aux_r |->
    {DAT_O[31:8], DAT_O[6:0]} == {24'h0, 7'h1F})
    else $error("aux reserved bits wrong");
  // Timer outputs against the control shadow
  AST_COMBINE: assert property (!$past(RST) && $past(tx) |->
    TIMER_OUT == mix($past(lf), $past(SHORT_TIMER_OUTPUT),
    $past(LONG_TIMER_OUTPUT))) else $error("combined output wrong");
  AST_FORCE_LO: assert property ((tx && sub == SUB_FORCE0)[*2] |->
    !LONG_TIMER_OUTPUT) else $error("long not forced low");
  AST_FORCE_HI: assert property ((tx && sub == SUB_FORCE1)[*2] |->
    LONG_TIMER_OUTPUT) else $error("long not forced high");
  AST_SHORT_IDLE: assert property ((tx && !sen_r)[*2] |->
    SHORT_TIMER_OUTPUT == !$past(ins)) else $error("short idle wrong");
  AST_LONG_IDLE: assert property ((tx && !len_r && !sub[1])[*2] |->
    LONG_TIMER_OUTPUT == !$past(inl)) else $error("long idle wrong");
  AST_SHORT_START: assert property (tx && $rose(sen_r) |->
    SHORT_TIMER_OUTPUT == !ins ##1 SHORT_TIMER_OUTPUT == ins)
    else $error("short start level wrong");
  AST_LONG_START: assert property (tx && !sub[1] && $rose(len_r) |->
    LONG_TIMER_OUTPUT == !inl ##1 LONG_TIMER_OUTPUT == inl)
    else $error("long start level wrong");
endmodule

bind timer_pair timer_pair_sva chk (.CLK, .RST, .CYC_I, .STB_I, .WE_I,
  .ADR_I, .SEL_I, .DAT_I, .DAT_O, .ACK_O, .SHORT_TIMER_OUTPUT,
  .LONG_TIMER_OUTPUT, .TIMER_OUT);

// ==== verif/edge_source.sv ====
// Far-side source driving the two edge input pins
`timescale 1ns/1ps
module edge_source (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic level,
  input  wire logic use_b,
  output logic      pin_a,
  output logic      pin_b
);
  // Idle pin chatters every cycle so a wrong pin choice shows up
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_a <= 1'b0;
      pin_b <= 1'b0;
    end else begin
      pin_a <= use_b ? ~pin_a : level;
      pin_b <= use_b ? level : ~pin_b;
    end
  end
endmodule

// ==== verif/tb_top.sv ====
// Self-checking bench for the timer pair block
`timescale 1ns/1ps
module tb_top;
  import timer_pair_pkg::*;
  logic        clk, rst, cyc, stb, we, ack, pa, pb, lvl, use_b;
  logic        s_out, l_out, t_out;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat_w, dat_r, rd;
  int          errors, num_checks;

  timer_pair dut (.CLK(clk), .RST(rst), .CYC_I(cyc), .STB_I(stb),
    .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(dat_w), .DAT_O(dat_r),
    .ACK_O(ack), .EDGE_INPUT_PIN_A(pa), .EDGE_INPUT_PIN_B(pb),
    .SHORT_TIMER_OUTPUT(s_out), .LONG_TIMER_OUTPUT(l_out),
    .TIMER_OUT(t_out));
  edge_source src (.clk(clk), .rst(rst), .level(lvl), .use_b(use_b),
    .pin_a(pa), .pin_b(pb));

  ////////////////////////////////////////////////////////////////////////
  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  function automatic logic mix(input logic [1:0] f, input logic s, l);
    case (f)
      LF_AND:  mix = s & l;
      LF_OR:   mix = s | l;
      LF_NOR:  mix = ~(s | l);
      default: mix = ~(s & l);
    endcase
  endfunction

  task automatic chk(input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One classic cycle; holds everything until ack is sampled high
  task automatic bus(input logic w, input logic [5:0] i,
                     input logic [7:0] d, input logic [3:0] s);
    int n = 0;
    @(posedge clk);
    cyc   <= 1'b1;
    stb   <= 1'b1;
    we    <= w;
    adr   <= {i, 2'h0};
    sel   <= s;
    dat_w <= {24'h0, d};
    @(posedge clk);
    while (ack !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, ack}, 32'h1);
    rd = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    bus(1'b1, i, d, 4'hF);
  endtask

  task automatic exp_rd(input logic [5:0] i, input logic [7:0] e);
    bus(1'b0, i, 8'h00, 4'hF);
    chk(rd, {24'h0, e});
  endtask

  // Outputs settle one edge, the combined one a further edge
  task automatic outs(input logic [2:0] e);
    repeat (2) @(negedge clk);
    chk({29'h0, s_out, l_out, t_out}, {29'h0, e});
  endtask

  task automatic drive(input logic v, input int n);
    lvl <= v;
    repeat (n) @(posedge clk);
  endtask

  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    {rst, cyc, stb, we, lvl, use_b, adr, sel, dat_w} = '0;
    rst = 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    outs(3'b111);
    exp_rd(IDX_MODE_CTL, 8'h00);
    exp_rd(IDX_LONG_CTL, 8'h00);
    exp_rd(IDX_AUX_CTL, 8'h1F);
    exp_rd(IDX_SHORT_RELOAD, 8'h0F);
    exp_rd(IDX_LONG_RELOAD_LO, 8'hFF);
    exp_rd(IDX_LONG_RELOAD_HI, 8'h00);
    exp_rd(IDX_STATUS, 8'h0E);
    wr(6'h00, 8'hFF);
    exp_rd(6'h00, 8'h00);
    bus(1'b1, IDX_MODE_CTL, 8'h30, 4'hE);
    exp_rd(IDX_MODE_CTL, 8'h00);
    wr(IDX_AUX_CTL, 8'h60);
    exp_rd(IDX_AUX_CTL, 8'h1F);
    $display("register map test done");
    for (int k = 0; k < 8; k++) begin
      wr(IDX_MODE_CTL, {2'h0, k[1:0], 3'h0, k[2]});
      outs({1'b1, ~k[2], mix(k[1:0], 1'b1, ~k[2])});
    end
    wr(IDX_MODE_CTL, 8'h09);
    outs(3'b100);
    wr(IDX_MODE_CTL, 8'h0C);
    outs(3'b111);
    $display("logic and force test done");
    wr(IDX_SHORT_RELOAD, 8'h02);
    wr(IDX_LONG_RELOAD_LO, 8'h03);
    wr(IDX_MODE_CTL, 8'h02);
    outs(3'b010);
    wr(IDX_LONG_CTL, 8'h80);
    wr(IDX_AUX_CTL, 8'h80);
    @(negedge clk);
    chk({31'h0, s_out}, 32'h1);
    repeat (2) @(negedge clk);
    chk({31'h0, s_out}, 32'h1);
    @(negedge clk);
    chk({31'h0, s_out}, 32'h0);
    wr(IDX_MODE_CTL, 8'h06);
    rd = '0;
    for (int k = 0; k < 40 && rd[0] !== 1'b1; k++)
      bus(1'b0, IDX_STATUS, 8'h00, 4'hF);
    chk({31'h0, rd[0]}, 32'h1);
    wr(IDX_MODE_CTL, 8'h02);
    // Back in normal submode the turn must return to the short timer
    bus(1'b0, IDX_STATUS, 8'h00, 4'hF);
    chk({31'h0, rd[0]}, 32'h0);
    wr(IDX_AUX_CTL, 8'h00);
    wr(IDX_LONG_CTL, 8'h00);
    outs(3'b010);
    $display("timer start test done");
    wr(IDX_MODE_CTL, 8'hA4);
    drive(1'b1, 12);
    exp_rd(IDX_MODE_CTL, 8'hA6);
    drive(1'b0, 1);
    drive(1'b1, 12);
    exp_rd(IDX_MODE_CTL, 8'hA6);
    wr(IDX_MODE_CTL, 8'hA6);
    exp_rd(IDX_MODE_CTL, 8'hA4);
    drive(1'b0, 12);
    exp_rd(IDX_MODE_CTL, 8'hA5);
    wr(IDX_MODE_CTL, 8'h99);
    exp_rd(IDX_MODE_CTL, 8'h98);
    drive(1'b1, 12);
    drive(1'b0, 12);
    exp_rd(IDX_MODE_CTL, 8'h9A);
    use_b <= 1'b1;
    drive(1'b1, 12);
    wr(IDX_MODE_CTL, 8'hCE);
    drive(1'b1, 12);
    exp_rd(IDX_MODE_CTL, 8'hCC);
    drive(1'b0, 16);
    exp_rd(IDX_MODE_CTL, 8'hCD);
    // Second both-edges code and the one-cycle filter on pin b
    wr(IDX_MODE_CTL, 8'hF3);
    exp_rd(IDX_MODE_CTL, 8'hF0);
    drive(1'b1, 4);
    drive(1'b0, 4);
    exp_rd(IDX_MODE_CTL, 8'hF3);
    $display("demodulation test done");
    summarize();
  end

  // Watchdog
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    $display("Error at %0t: watchdog expired", $time);
    summarize();
  end
endmodule
